// ==== hw/periodic_tick_counter.sv ====
// Purpose: periodic tick counter with source select, prescaler, modulo and tick interrupt
// Assumes: oscillator inputs are synchronous to i_clk_sys and slower than it
// Notes: registers reached over classic Wishbone; see tick_counter_map.svh
`timescale 1ns/100ps
`default_nettype none
`include "tick_counter_map.svh"
module periodic_tick_counter
  import tick_counter_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // ------------------------------------------------------------
  // clock sources
  // ------------------------------------------------------------
  input wire logic i_external_crystal_osc,
  input wire logic i_low_power_osc,
  // ------------------------------------------------------------
  // interrupt and tick
  // ------------------------------------------------------------
  output logic o_irq,
  output logic o_tick_pulse
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  generate
    if (COUNT_W != 16) begin : g_bad_count
      $error("count width must be 16 to fit the byte-wise count registers");
    end
  endgenerate

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg_access_if acc ();

  clk_sel_t clock_source_select_r;
  ps_sel_t prescale_select_r;
  logic [COUNT_W-1:0] modulo_buf_r;
  logic [COUNT_W-1:0] modulo_act_r;
  logic [COUNT_W-1:0] tick_count_value_r;
  logic [7:0] count_high_latch_r;
  logic tick_flag_r;
  logic tick_irq_enable_r;
  logic irq_r;
  logic tick_pulse_r;
  logic ext_prev_r;
  logic lpo_prev_r;

  logic src_tick;
  logic ps_tick;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_enable;
  logic wr_modulo;
  logic rd_cnt_low;
  logic ctrl_change;
  logic ps_start;
  logic match;
  logic flag_set;
  logic flag_clr;
  clk_sel_t cs_new;
  ps_sel_t ps_new;
  logic [31:0] rdata;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  tick_wb_slave u_wb (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat),
    .acc(acc.bus_side)
  );

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  // write strobes per writable register, read strobe for count low only
  assign wr_ctrl = acc.req & acc.we & (acc.addr == `TC_OFF_CTRL) & acc.sel[0];
  assign wr_clear = acc.req & acc.we & (acc.addr == `TC_OFF_CLEAR) & acc.sel[0];
  assign wr_enable = acc.req & acc.we & (acc.addr == `TC_OFF_ENABLE) & acc.sel[0];
  assign wr_modulo = acc.req & acc.we & (acc.addr == `TC_OFF_MODULO) & (|acc.sel[1:0]);
  assign rd_cnt_low = acc.req & ~acc.we & (acc.addr == `TC_OFF_CNT_LOW);

  // new control field values from the written byte
  assign cs_new = acc.wdata[`TC_CS_MSB:`TC_CS_LSB];
  assign ps_new = acc.wdata[`TC_PS_MSB:`TC_PS_LSB];

  // a differing source or ratio restarts prescaler and counter
  assign ctrl_change = wr_ctrl &
                       ((cs_new != clock_source_select_r) || // RULE5
                        (ps_new != prescale_select_r)); // RULE6

  // prescaler leaving the off state
  assign ps_start = wr_ctrl & (prescale_select_r == `TC_PS_OFF) & (ps_new != `TC_PS_OFF);

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // source select and prescale select
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      clock_source_select_r <= `TC_CS_RESET; // RULE3
      prescale_select_r <= `TC_PS_RESET; // RULE2
    end else if (wr_ctrl) begin
      clock_source_select_r <= cs_new;
      prescale_select_r <= ps_new; // RULE4
    end
  end

  // ------------------------------------------------------------
  // clock source selection
  // ------------------------------------------------------------
  // previous levels for rising edge detection of slow sources
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ext_prev_r <= 1'b0;
      lpo_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= i_external_crystal_osc;
      lpo_prev_r <= i_low_power_osc;
    end
  end

  // one pulse per source edge; bus clock ticks every cycle
  always_comb begin
    unique case (clock_source_select_r) // RULE13
      2'h0: src_tick = i_external_crystal_osc & ~ext_prev_r;
      2'h1: src_tick = i_low_power_osc & ~lpo_prev_r;
      2'h2: src_tick = 1'b1;
      2'h3: src_tick = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  tick_prescaler #(
    .DIV_W(12)
  ) u_ps (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_src_tick(src_tick),
    .i_clear(ctrl_change),
    .i_code(prescale_select_r),
    .i_high_range(clock_source_select_r[0]),
    .o_tick(ps_tick)
  );

  // ------------------------------------------------------------
  // modulo buffer and active compare value
  // ------------------------------------------------------------
  // match when active and the count equals the compare value
  assign match = ps_tick & (prescale_select_r != `TC_PS_OFF) & ~ctrl_change &
                 (tick_count_value_r == modulo_act_r); // RULE17

  // software side buffer, byte lanes 0 and 1
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      modulo_buf_r <= `TC_MOD_RESET; // RULE2
    end else if (wr_modulo) begin
      if (acc.sel[0]) begin
        modulo_buf_r[7:0] <= acc.wdata[7:0]; // RULE7
      end
      if (acc.sel[1]) begin
        modulo_buf_r[15:8] <= acc.wdata[15:8]; // RULE7
      end
    end
  end

  // compare value taken over on wrap or prescaler start
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      modulo_act_r <= `TC_MOD_RESET; // RULE2
    end else if (match || ps_start) begin
      modulo_act_r <= modulo_buf_r; // RULE10
    end
  end

  // ------------------------------------------------------------
  // main counter
  // ------------------------------------------------------------
  // count up on prescaler pulses, wrap to zero on match
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_count_value_r <= `TC_CNT_RESET; // RULE2
    end else if (ctrl_change) begin
      tick_count_value_r <= `TC_CNT_RESET; // RULE5 RULE6
    end else if (match) begin
      tick_count_value_r <= `TC_CNT_RESET; // RULE8 RULE15
    end else if (ps_tick && prescale_select_r != `TC_PS_OFF) begin
      tick_count_value_r <= tick_count_value_r + 1'b1; // RULE1 RULE8
    end
  end

  // high byte frozen by a low byte read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      count_high_latch_r <= 8'h00;
    end else if (rd_cnt_low) begin
      count_high_latch_r <= tick_count_value_r[15:8]; // RULE16
    end
  end

  // ------------------------------------------------------------
  // tick flag and interrupt
  // ------------------------------------------------------------
  assign flag_set = match; // RULE9 RULE15
  assign flag_clr = wr_clear & acc.wdata[`TC_FLAG_BIT]; // RULE12 RULE18

  // sticky flag, a set in the clearing cycle wins
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_flag_r <= 1'b0;
    end else if (flag_set) begin
      tick_flag_r <= 1'b1; // RULE9
    end else if (flag_clr) begin
      tick_flag_r <= 1'b0; // RULE12
    end
  end

  // interrupt enable
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_irq_enable_r <= 1'b0;
    end else if (wr_enable) begin
      tick_irq_enable_r <= acc.wdata[`TC_IE_BIT];
    end
  end

  // registered interrupt level and tick strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      irq_r <= 1'b0;
      tick_pulse_r <= 1'b0;
    end else begin
      irq_r <= tick_flag_r & tick_irq_enable_r; // RULE11
      tick_pulse_r <= match;
    end
  end

  assign o_irq = irq_r;
  assign o_tick_pulse = tick_pulse_r;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // unmapped and write-only addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (acc.addr)
      `TC_OFF_CTRL: begin
        rdata[`TC_CS_MSB:`TC_CS_LSB] = clock_source_select_r;
        rdata[`TC_PS_MSB:`TC_PS_LSB] = prescale_select_r;
      end
      `TC_OFF_STATUS: rdata[`TC_FLAG_BIT] = tick_flag_r;
      `TC_OFF_ENABLE: rdata[`TC_IE_BIT] = tick_irq_enable_r;
      `TC_OFF_MODULO: rdata[15:0] = modulo_buf_r;
      `TC_OFF_CNT_LOW: rdata[7:0] = tick_count_value_r[7:0];
      `TC_OFF_CNT_HIGH: rdata[7:0] = count_high_latch_r; // RULE16
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign acc.rdata = rdata;

endmodule
`default_nettype wire

// ==== hw/tick_counter_map.svh ====
// Purpose: register map, field positions, reset values for the periodic tick counter
// Assumes: 32-bit classic Wishbone, byte addresses, one register per aligned word
// Notes: included by bare name; definitions only
//
// Function
// [RULE1] 16-bit up-counter against 16-bit modulo, source selector, binary/decimal prescaler.
// [RULE2] any reset stops and clears counter, clears modulo, prescaler off.
// [RULE3] reset selects external crystal oscillator, clock select code zero.
// [RULE4] prescale select zero keeps prescaler off; software starts it with nonzero.
// [RULE5] writing a different clock source clears prescaler and counter.
// [RULE6] writing a different prescale select clears prescaler and counter.
// [RULE7] modulo accepts any value from zero to all ones.
// [RULE8] active counter increments to modulo, wraps to zero, keeps counting.
// [RULE9] tick flag sets on every match, when counter steps modulo to zero.
// [RULE10] written modulo buffered; used on wrap or when prescale select becomes nonzero.
// [RULE11] interrupt requested while tick flag and tick interrupt enable are set.
// [RULE12] tick flag cleared only by software writing one; software acknowledges each tick.
// [RULE13] source code 0 external, 1 low-power 1 kHz, 2 and 3 bus clock.
// [RULE14] codes 1..7 divide 1..64 binary, or 128..2048, 100, 1000 with select bit0.
// [RULE15] modulo zero sets tick flag on every prescaler output edge.
// [RULE16] reading count low byte latches high byte for coherent following read.
// [RULE17] prescaler off holds counter, no match, no flag.
// [RULE18] writing zero to tick flag does nothing; flag sticks until cleared or reset.
`ifndef TICK_COUNTER_MAP_SVH
`define TICK_COUNTER_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define TC_OFF_CTRL 8'h00
`define TC_OFF_STATUS 8'h04
`define TC_OFF_CLEAR 8'h08
`define TC_OFF_ENABLE 8'h0C
`define TC_OFF_MODULO 8'h10
`define TC_OFF_CNT_LOW 8'h14
`define TC_OFF_CNT_HIGH 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TC_CS_MSB 7
`define TC_CS_LSB 6
`define TC_PS_MSB 2
`define TC_PS_LSB 0
`define TC_FLAG_BIT 0
`define TC_IE_BIT 0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TC_CS_RESET 2'h0
`define TC_PS_RESET 3'h0
`define TC_MOD_RESET 16'h0000
`define TC_CNT_RESET 16'h0000
`define TC_PS_OFF 3'h0

`endif

// ==== hw/tick_counter_pkg.sv ====
// Purpose: shared types and the divide ratio decode of the periodic tick counter
// Assumes: prescaler count fits 12 bits (largest ratio 2048)
// Notes: constants live in tick_counter_map.svh
package tick_counter_pkg;

  typedef logic [1:0] clk_sel_t;
  typedef logic [2:0] ps_sel_t;
  typedef logic [11:0] ratio_t;

  // divide ratio for a prescale code; high range when source select bit0 set
  function automatic ratio_t ps_ratio(input ps_sel_t code, input logic high_range);
    ratio_t r;
    r = 12'h001;
    unique case (code)
      3'h1: r = high_range ? 12'h080 : 12'h001;
      3'h2: r = high_range ? 12'h100 : 12'h002;
      3'h3: r = high_range ? 12'h200 : 12'h004;
      3'h4: r = high_range ? 12'h400 : 12'h008;
      3'h5: r = high_range ? 12'h800 : 12'h010;
      3'h6: r = high_range ? 12'h064 : 12'h020;
      3'h7: r = high_range ? 12'h3E8 : 12'h040;
      3'h0: r = 12'h001;
    endcase
    return r;
  endfunction

endpackage

// ==== hw/reg_access_if.sv ====
// Purpose: register access strobes between the bus slave and the register file
// Assumes: one access per req pulse
// Notes: rdata must be valid combinationally in the req cycle
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [3:0] sel;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus_side (output req, output we, output addr, output sel, output wdata,
                    input rdata);
  modport reg_side (input req, input we, input addr, input sel, input wdata,
                    output rdata);
endinterface
`default_nettype wire

// ==== hw/tick_wb_slave.sv ====
// Purpose: classic Wishbone slave turning a bus cycle into one register access
// Assumes: master holds the request until ack
// Notes: ack one cycle after request, dropped the cycle after
`timescale 1ns/100ps
`default_nettype none
module tick_wb_slave (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  reg_access_if.bus_side acc
);
  logic ack_r;
  logic [31:0] dat_r;

  // one access per cycle, never while ack is up
  assign acc.req = i_wb_cyc & i_wb_stb & ~ack_r;
  assign acc.we = i_wb_we;
  assign acc.addr = {i_wb_adr[7:2], 2'h0};
  assign acc.sel = i_wb_sel;
  assign acc.wdata = i_wb_dat;

  // acknowledge and read data capture
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= acc.req;
      if (acc.req) begin
        dat_r <= acc.we ? 32'h0000_0000 : acc.rdata;
      end
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = dat_r;
endmodule
`default_nettype wire

// ==== hw/tick_prescaler.sv ====
// Purpose: binary/decimal prescaler producing one pulse per divided source edge
// Assumes: i_src_tick is a one-cycle pulse per source rising edge
// Notes: code zero holds the prescaler off and cleared
`timescale 1ns/100ps
`default_nettype none
`include "tick_counter_map.svh"
module tick_prescaler
  import tick_counter_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_src_tick,
  input wire logic i_clear,
  input wire tick_counter_pkg::ps_sel_t i_code,
  input wire logic i_high_range,
  output logic o_tick
);
  logic [DIV_W-1:0] div_cnt_r;
  logic tick_r;
  ratio_t ratio;

  generate
    if (DIV_W < 12) begin : g_bad_width
      $error("prescaler width too small for a ratio of 2048");
    end
  endgenerate

  assign ratio = ps_ratio(i_code, i_high_range); // RULE14

  // divide counter, cleared on off state or source/ratio change
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_clear || i_code == `TC_PS_OFF) begin // RULE4
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (i_src_tick) begin
      if (div_cnt_r == DIV_W'(ratio - 12'h001)) begin // RULE14
        div_cnt_r <= '0;
        tick_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 1'b1;
        tick_r <= 1'b0;
      end
    end else begin
      tick_r <= 1'b0;
    end
  end

  assign o_tick = tick_r;
endmodule
`default_nettype wire

// ==== verification/periodic_tick_counter_sva.sv ====
// Purpose: port-level assertions for periodic_tick_counter
// Assumes: classic Wishbone master, aligned addresses
// Notes: enable and prescale state shadowed from taken writes
`timescale 1ns/100ps
`default_nettype none
`include "tick_counter_map.svh"
module periodic_tick_counter_sva #(
  parameter int COUNT_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic i_external_crystal_osc,
  input wire logic i_low_power_osc,
  input wire logic o_irq,
  input wire logic o_tick_pulse
);
  logic wr_taken;
  logic en_r;
  logic ps_off_r;
  // ------------------------------------------------------------
  // shadow state
  // ------------------------------------------------------------
  // write as the slave takes it, low lane enabled
  assign wr_taken = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0];
  // interrupt enable as last written
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      en_r <= 1'b0;
    end else if (wr_taken && i_wb_adr == `TC_OFF_ENABLE) begin
      en_r <= i_wb_dat[0];
    end
  end
  // prescaler off as last written
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ps_off_r <= 1'b1;
    end else if (wr_taken && i_wb_adr == `TC_OFF_CTRL) begin
      ps_off_r <= (i_wb_dat[2:0] == 3'h0);
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_answers: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not acknowledged next cycle");
  a_write_reads_zero: assert property (o_wb_ack && $past(i_wb_we) |-> o_wb_dat == 32'h0000_0000)
    else $error("read data not zero on write");
  a_reset_quiet: assert property ($past(i_rst) |-> !o_irq && !o_tick_pulse && !o_wb_ack)
    else $error("outputs active right after reset");
  a_unmapped_zero: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr > 8'h1B)
    |-> o_wb_dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_flag_reg_narrow: assert property (o_wb_ack && $past(!i_wb_we &&
    (i_wb_adr == `TC_OFF_STATUS || i_wb_adr == `TC_OFF_ENABLE)) |-> o_wb_dat[31:1] == 31'h0)
    else $error("status or enable upper bits set");
  a_count_narrow: assert property (o_wb_ack && $past(!i_wb_we &&
    (i_wb_adr == `TC_OFF_CNT_LOW || i_wb_adr == `TC_OFF_CNT_HIGH)) |-> o_wb_dat[31:8] == 24'h0)
    else $error("count byte read wider than eight bits");
  a_irq_masked: assert property (!en_r && !$past(en_r) |-> !o_irq)
    else $error("interrupt raised while disabled");
  a_irq_fall_write: assert property ($fell(o_irq) |-> $past(i_wb_stb && i_wb_we, 2))
    else $error("interrupt dropped without a write");
  a_off_no_tick: assert property (ps_off_r && $past(ps_off_r, 2) |-> !o_tick_pulse)
    else $error("tick while prescaler off");
  c_irq_seen: cover property (o_irq);
  c_tick_enabled: cover property (o_tick_pulse && en_r);
  c_irq_cleared: cover property ($fell(o_irq));
endmodule
bind periodic_tick_counter periodic_tick_counter_sva #(.COUNT_W(COUNT_W)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_external_crystal_osc(i_external_crystal_osc),
  .i_low_power_osc(i_low_power_osc), .o_irq(o_irq), .o_tick_pulse(o_tick_pulse));
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench for periodic_tick_counter
// Assumes: oscillators made here as slow toggles on the system clock
// Notes: tick spacing measured on o_tick_pulse
`timescale 1ns/100ps
`default_nettype none
`include "tick_counter_map.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic ext_osc = 1'b0;
  logic lp_osc = 1'b0;
  logic ack;
  logic irq;
  logic tick;
  logic [31:0] rdat;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc_n = 0;
  int ack_cyc = 0;
  int ext_c = 0;
  int lp_c = 0;
  periodic_tick_counter #(.COUNT_W(16)) DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_external_crystal_osc(ext_osc), .i_low_power_osc(lp_osc), .o_irq(irq),
    .o_tick_pulse(tick));
  // ------------------------------------------------------------
  // clock, oscillators (period 8 and 20), cycle stamp
  // ------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    ext_c <= (ext_c == 3) ? 0 : ext_c + 1;
    lp_c <= (lp_c == 9) ? 0 : lp_c + 1;
    if (ext_c == 3) ext_osc <= ~ext_osc;
    if (lp_c == 9) lp_osc <= ~lp_osc;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    ack_cyc = cyc_n;
    cyc <= 1'b0;
    stb <= 1'b0;
    check(n < 50, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    check(q, e);
  endtask
  // cycles until the next tick pulse
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 4000);
    check(n < 4000, 1'b1);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`TC_OFF_CTRL, 32'h0000_0000);
    rd_chk(`TC_OFF_MODULO, 32'h0000_0000);
    rd_chk(`TC_OFF_CNT_LOW, 32'h0000_0000);
    rd_chk(`TC_OFF_STATUS, 32'h0000_0000);
    rd_chk(`TC_OFF_ENABLE, 32'h0000_0000);
  endtask
  task automatic t_dividers();
    logic [7:0] ctl[16] = '{8'h01, 8'h46, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
                            8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
    int gap[16] = '{8, 2000, 1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 1024, 2048, 100, 1000};
    int n;
    for (int i = 0; i < 16; i++) begin
      wr(`TC_OFF_CTRL, 32'h0000_0000);
      wr(`TC_OFF_CTRL, {24'h0, ctl[i]});
      wait_tick(n);
      wait_tick(n);
      check(n, gap[i]);
    end
  endtask
  task automatic t_modulo();
    int n;
    wr(`TC_OFF_CTRL, 32'h0000_0000);
    wr(`TC_OFF_MODULO, 32'h0000_0005);
    wr(`TC_OFF_CTRL, 32'h0000_0081);
    wait_tick(n);
    wait_tick(n);
    check(n, 6);
    wr(`TC_OFF_MODULO, 32'h0000_0009);
    repeat (3) wait_tick(n);
    check(n, 10);
    wr(`TC_OFF_MODULO, 32'h0000_0000);
    repeat (3) wait_tick(n);
    check(n, 1);
  endtask
  task automatic t_flag_irq();
    int n;
    int k;
    wr(`TC_OFF_ENABLE, 32'h0000_0001);
    wait_tick(n);
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    wr(`TC_OFF_CTRL, 32'h0000_0080);
    rd_chk(`TC_OFF_CNT_LOW, 32'h0000_0000);
    rd_chk(`TC_OFF_STATUS, 32'h0000_0001);
    wr(`TC_OFF_CLEAR, 32'h0000_0000);
    rd_chk(`TC_OFF_STATUS, 32'h0000_0001);
    wr(`TC_OFF_CLEAR, 32'h0000_0001);
    rd_chk(`TC_OFF_STATUS, 32'h0000_0000);
    k = 0;
    repeat (50) begin
      @(negedge clk);
      if (tick === 1'b1) k++;
    end
    check(k, 0);
    check(irq, 1'b0);
    wr(`TC_OFF_ENABLE, 32'h0000_0000);
    wr(`TC_OFF_CTRL, 32'h0000_0081);
    wait_tick(n);
    wr(`TC_OFF_CTRL, 32'h0000_0080);
    rd_chk(`TC_OFF_STATUS, 32'h0000_0001);
    check(irq, 1'b0);
    wr(`TC_OFF_CLEAR, 32'h0000_0001);
  endtask
  task automatic t_count();
    logic [31:0] l1;
    logic [31:0] h1;
    logic [31:0] l2;
    logic [31:0] h2;
    int t1;
    wr(`TC_OFF_MODULO, 32'h0000_FFFF);
    rd_chk(`TC_OFF_MODULO, 32'h0000_FFFF);
    wr(`TC_OFF_CTRL, 32'h0000_0081);
    rd(`TC_OFF_CNT_LOW, l1);
    t1 = ack_cyc;
    repeat (300) @(posedge clk);
    rd(`TC_OFF_CNT_HIGH, h1);
    rd(`TC_OFF_CNT_LOW, l2);
    // count steps once per cycle, so it advances by the cycles between the low reads
    t1 = ack_cyc - t1;
    repeat (300) @(posedge clk);
    rd(`TC_OFF_CNT_HIGH, h2);
    check({h2[7:0], l2[7:0]} - {h1[7:0], l1[7:0]}, t1);
    wr(`TC_OFF_CTRL, 32'h0000_00C1);
    rd_chk(`TC_OFF_CNT_LOW, 32'h0000_0000);
    wr(`TC_OFF_CTRL, 32'h0000_0081);
    repeat (50) @(posedge clk);
    wr(`TC_OFF_CTRL, 32'h0000_0087);
    rd_chk(`TC_OFF_CNT_LOW, 32'h0000_0000);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd_chk(8'h1C, 32'h0000_0000);
    rd_chk(`TC_OFF_CTRL, 32'h0000_0087);
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    t_reset();
    t_dividers();
    t_modulo();
    t_flag_irq();
    t_count();
    t_reset();
    end_of_test();
  end
  // tests need about 20k cycles; give up after 60k
  initial begin
    #600000;
    n_fail++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
